/* File: hdl/begs_defs.vh */
// Functional notes
// - device finishes processing between min and max wait, then sends status.
// - signature exchange: next transfer only after the minimum wait has elapsed.
// - range erase runs as a series of multi-block group erase passes.
// - group size is a power of two from 1 to 128 blocks.
// - candidate allowed if not above remaining count and first index aligned to it.
// - the largest allowed candidate is chosen for each pass.
// - search starts at 128 and halves until both tests pass.
// - after each pass advance first index, reduce remaining, reselect group size.
`ifndef BEGS_DEFS_VH
`define BEGS_DEFS_VH
`define BEGS_CLK_HZ          20000000
`define BEGS_MAX_GROUP       128
`define BEGS_ERASE_MIN_US    17500
`define BEGS_SIG_WAIT_NS     66000
`define BEGS_ERASE_MIN_CYC   ((`BEGS_ERASE_MIN_US * (`BEGS_CLK_HZ / 1000000)))
`define BEGS_SIG_WAIT_CYC    ((`BEGS_SIG_WAIT_NS * (`BEGS_CLK_HZ / 1000000) + 999) / 1000)
`define BEGS_ST_IDLE         3'h0
`define BEGS_ST_SELECT       3'h1
`define BEGS_ST_PASS         3'h2
`define BEGS_ST_WAIT         3'h3
`define BEGS_ST_MINHOLD      3'h4
`define BEGS_ST_REPLY        3'h5
`endif

/* File: hdl/begs_group_select.v */
`timescale 1ns/1ps
`default_nettype none
`include "begs_defs.vh"
module begs_group_select #(
  parameter IDX_W = 10
) (
  input  wire [IDX_W-1:0] first_block_index,
  input  wire [IDX_W:0]   blocks_remaining,
  output reg  [7:0]       group_size
);
  integer k;
  reg     found;
  reg [IDX_W:0] cand;
  // search from the top and halve; first fit is the largest allowed
  always @* begin
    group_size = 8'h01;
    found      = 1'b0;
    cand       = {(IDX_W+1){1'b0}};
    for (k = 7; k >= 0; k = k - 1) begin
      cand = {{(IDX_W){1'b0}}, 1'b1} << k;
      // alignment means every bit below the candidate is clear
      if (!found && (blocks_remaining >= cand) &&
          ((first_block_index & (cand[IDX_W-1:0] - 1'b1)) == {IDX_W{1'b0}})) begin
        group_size = 8'h01 << k;
        found      = 1'b1;
      end
    end
  end
endmodule // begs_group_select
`default_nettype wire

/* File: hdl/begs_block_erase_sequencer.v */
`timescale 1ns/1ps
`default_nettype none
`include "begs_defs.vh"
module begs_block_erase_sequencer #(
  parameter IDX_W       = 10,
  parameter ERASE_MIN   = `BEGS_ERASE_MIN_CYC,
  parameter SIG_WAIT    = `BEGS_SIG_WAIT_CYC
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             start,
  input  wire [IDX_W-1:0] first_block_index,
  input  wire [IDX_W-1:0] last_block_index,
  input  wire             erase_done,
  input  wire             sig_xfer_end,
  output reg              busy,
  output reg              erase_req,
  output reg  [IDX_W-1:0] erase_first_index,
  output reg  [7:0]       group_size,
  output reg  [IDX_W:0]   pass_count,
  output reg              status_valid,
  output reg              range_error,
  output reg              sig_ready
);
  // sequencer state and datapath registers
  reg  [2:0]       state_q;
  reg  [2:0]       state_d;
  reg  [IDX_W-1:0] first_q;
  reg  [IDX_W-1:0] first_d;
  reg  [IDX_W:0]   remaining_q;
  reg  [IDX_W:0]   remaining_d;
  // 32 bits so the full-speed minimum hold fits with room to spare
  reg  [31:0]      elapsed_q;
  reg  [31:0]      elapsed_d;
  reg  [31:0]      sig_cnt_q;
  reg  [31:0]      sig_cnt_d;

  // next values of the registered outputs
  reg              busy_d;
  reg              erase_req_d;
  reg  [IDX_W-1:0] erase_first_d;
  reg  [7:0]       group_size_d;
  reg  [IDX_W:0]   pass_count_d;
  reg              status_valid_d;
  reg              range_error_d;
  reg              sig_ready_d;

  // helper nets
  wire [7:0]       sel_size;
  wire             range_rev;
  wire [IDX_W:0]   range_count;
  wire [IDX_W-1:0] size_idx;
  wire [IDX_W:0]   size_cnt;
  wire [IDX_W-1:0] first_next;
  wire [IDX_W:0]   remaining_next;
  wire [IDX_W:0]   pass_next;
  wire [31:0]      elapsed_next;
  wire [31:0]      sig_cnt_next;
  wire             min_hold_done;
  wire             sig_gap_done;
  wire             range_empty;

  assign range_rev      = (last_block_index < first_block_index);
  assign range_count    = {1'b0, last_block_index} - {1'b0, first_block_index}
                          + {{IDX_W{1'b0}}, 1'b1};
  // group size widened on purpose to the index and count widths
  assign size_idx       = {{(IDX_W-8){1'b0}}, group_size};
  assign size_cnt       = {{(IDX_W-7){1'b0}}, group_size};
  assign first_next     = first_q + size_idx;
  assign remaining_next = remaining_q - size_cnt;
  assign pass_next      = pass_count + {{IDX_W{1'b0}}, 1'b1};
  assign elapsed_next   = elapsed_q + 32'h00000001;
  assign sig_cnt_next   = sig_cnt_q + 32'h00000001;
  assign min_hold_done  = (elapsed_q >= ERASE_MIN);
  assign sig_gap_done   = (sig_cnt_next >= SIG_WAIT);
  assign range_empty    = (remaining_q == {(IDX_W+1){1'b0}});

  // selector sees registered values only, so its depth stays off the state path
  begs_group_select #(.IDX_W(IDX_W)) u_sel (
    .first_block_index (first_q),
    .blocks_remaining  (remaining_q),
    .group_size        (sel_size)
  );

  // signature path: ready again only after the minimum gap
  always @* begin
    sig_cnt_d   = sig_cnt_q;
    sig_ready_d = sig_ready;
    if (sig_xfer_end) begin
      sig_cnt_d   = 32'h00000000;
      sig_ready_d = 1'b0;
    end else if (!sig_ready) begin
      sig_cnt_d = sig_cnt_next;
      if (sig_gap_done) begin
        sig_ready_d = 1'b1;
      end
    end
  end

  // range erase sequence
  always @* begin
    state_d        = state_q;
    first_d        = first_q;
    remaining_d    = remaining_q;
    elapsed_d      = elapsed_q;
    busy_d         = busy;
    erase_req_d    = 1'b0;
    erase_first_d  = erase_first_index;
    group_size_d   = group_size;
    pass_count_d   = pass_count;
    status_valid_d = 1'b0;
    range_error_d  = range_error;
    if (state_q != `BEGS_ST_IDLE) begin
      elapsed_d = elapsed_next;
    end
    case (state_q)
      `BEGS_ST_IDLE: begin
        // only idle looks at start, so a start while busy is dropped
        if (start) begin
          busy_d       = 1'b1;
          elapsed_d    = 32'h00000000;
          pass_count_d = {(IDX_W+1){1'b0}};
          first_d      = first_block_index;
          state_d      = `BEGS_ST_SELECT;
          // reversed range is refused with an error status
          if (range_rev) begin
            range_error_d = 1'b1;
            remaining_d   = {(IDX_W+1){1'b0}};
          end else begin
            range_error_d = 1'b0;
            remaining_d   = range_count;
          end
        end
      end
      `BEGS_ST_SELECT: begin
        if (range_empty) begin
          state_d = `BEGS_ST_MINHOLD;
        end else begin
          group_size_d  = sel_size;
          erase_first_d = first_q;
          erase_req_d   = 1'b1;
          state_d       = `BEGS_ST_WAIT;
        end
      end
      `BEGS_ST_WAIT: begin
        // a done outside this state is dropped; one done per request
        if (erase_done) begin
          first_d      = first_next;
          remaining_d  = remaining_next;
          pass_count_d = pass_next;
          state_d      = `BEGS_ST_SELECT;
        end
      end
      `BEGS_ST_MINHOLD: begin
        // status never leaves before the minimum processing time
        if (min_hold_done) begin
          state_d = `BEGS_ST_REPLY;
        end
      end
      `BEGS_ST_REPLY: begin
        status_valid_d = 1'b1;
        busy_d         = 1'b0;
        state_d        = `BEGS_ST_IDLE;
      end
      default: begin
        state_d = `BEGS_ST_IDLE;
      end
    endcase
  end

  // sequencer registers; outputs load straight from their next values
  always @(posedge clk) begin
    if (reset) begin
      state_q           <= `BEGS_ST_IDLE;
      first_q           <= {IDX_W{1'b0}};
      remaining_q       <= {(IDX_W+1){1'b0}};
      elapsed_q         <= 32'h00000000;
      busy              <= 1'b0;
      erase_req         <= 1'b0;
      erase_first_index <= {IDX_W{1'b0}};
      group_size        <= 8'h00;
      pass_count        <= {(IDX_W+1){1'b0}};
      status_valid      <= 1'b0;
      range_error       <= 1'b0;
    end else begin
      state_q           <= state_d;
      first_q           <= first_d;
      remaining_q       <= remaining_d;
      elapsed_q         <= elapsed_d;
      busy              <= busy_d;
      erase_req         <= erase_req_d;
      erase_first_index <= erase_first_d;
      group_size        <= group_size_d;
      pass_count        <= pass_count_d;
      status_valid      <= status_valid_d;
      range_error       <= range_error_d;
    end
  end

  // signature registers; ready out of reset, no transfer has ended yet
  always @(posedge clk) begin
    if (reset) begin
      sig_cnt_q <= 32'h00000000;
      sig_ready <= 1'b1;
    end else begin
      sig_cnt_q <= sig_cnt_d;
      sig_ready <= sig_ready_d;
    end
  end
endmodule // begs_block_erase_sequencer
`default_nettype wire

/* File: verif/begs_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module begs_flash_model (
  input  wire logic       clk,
  input  wire logic       erase_req,
  input  wire logic [7:0] dly,
  output var  logic       erase_done = 1'b0
);
  logic [7:0] cnt_q = 8'h00;
  logic       act_q = 1'b0;
  // exactly one done per request, dly cycles late so slow arrays are covered
  always @(posedge clk) begin
    erase_done <= act_q && cnt_q == 8'h00;
    if (erase_req) begin
      act_q <= 1'b1;
      cnt_q <= dly;
    end else if (act_q) begin
      act_q <= cnt_q != 8'h00;
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule // begs_flash_model
`default_nettype wire

/* File: verif/begs_seq_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module begs_seq_sva #(
  parameter IDX_W     = 10,
  parameter ERASE_MIN = 20,
  parameter SIG_WAIT  = 5
) (
  input wire logic             clk,
  input wire logic             reset,
  input wire logic             start,
  input wire logic             sig_xfer_end,
  input wire logic             busy,
  input wire logic             erase_req,
  input wire logic             status_valid,
  input wire logic             sig_ready,
  input wire logic [IDX_W-1:0] first_block_index,
  input wire logic [IDX_W-1:0] last_block_index,
  input wire logic [IDX_W-1:0] erase_first_index,
  input wire logic [7:0]       group_size,
  input wire logic [IDX_W:0]   pass_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire go = start && !busy;
  wire [IDX_W:0] g2 = {group_size, 1'b0};
  logic [IDX_W:0] rem_q;
  logic [IDX_W-1:0] nxt_q;
  int el_q = 0, sg_q = 0;
  always @(posedge clk) begin
    el_q <= go ? 0 : el_q + 1;
    sg_q <= sig_xfer_end ? 0 : sg_q + 1;
    if (go) rem_q <= last_block_index - first_block_index + 1'b1;
    else if (erase_req) rem_q <= rem_q - group_size;
    if (erase_req) nxt_q <= erase_first_index + group_size;
  end
  pow_two_a: assert property (erase_req |-> $onehot(group_size)) else $error("bad size");
  size_align_a: assert property (erase_req |-> (erase_first_index & (group_size - 1'b1)) == 0)
    else $error("group misaligned");
  size_fits_a: assert property (erase_req |-> group_size <= rem_q) else $error("group too big");
  size_max_a: assert property (erase_req && group_size != 8'h80 |->
    g2 > rem_q || (erase_first_index & (g2 - 1'b1)) != 0) else $error("group not largest");
  index_adv_a: assert property (erase_req && pass_count != 0 |-> erase_first_index == nxt_q)
    else $error("index not advanced");
  first_req_a: assert property (go && last_block_index >= first_block_index |->
    ##2 erase_req && pass_count == 0) else $error("first pass late");
  min_wait_a: assert property (status_valid |-> el_q >= ERASE_MIN && !busy) else $error("early");
  sig_gap_a: assert property ($rose(sig_ready) |-> sg_q == SIG_WAIT) else $error("gap");
  sig_drop_a: assert property (sig_xfer_end |=> !sig_ready) else $error("no drop");
  reply_end_a: assert property (status_valid |-> !busy && $past(busy)) else $error("busy");
  req_pulse_a: assert property (erase_req |=> !erase_req) else $error("req held");
  cover property (erase_req && group_size == 8'h80);
  cover property (status_valid && pass_count == 0);
  cover property ($rose(sig_ready));
endmodule // begs_seq_sva
bind begs_block_erase_sequencer begs_seq_sva #(.IDX_W(IDX_W), .ERASE_MIN(ERASE_MIN),
  .SIG_WAIT(SIG_WAIT)) chk (.clk(clk), .reset(reset), .start(start),
  .sig_xfer_end(sig_xfer_end), .busy(busy), .erase_req(erase_req), .status_valid(status_valid),
  .sig_ready(sig_ready), .first_block_index(first_block_index), .pass_count(pass_count),
  .last_block_index(last_block_index), .erase_first_index(erase_first_index),
  .group_size(group_size));
`default_nettype wire

/* File: verif/begs_block_erase_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module begs_block_erase_sequencer_bench;
  logic clk = 0, reset = 1, start = 0, sx = 0;
  logic [9:0] fi = 0, li = 0;
  logic [7:0] dly = 0;
  wire done, busy, req, stv, err, rdy;
  wire [9:0] efi;
  wire [7:0] gs;
  wire [10:0] pc;
  localparam int ERASE_MIN_SIM = 20;
  localparam int SIG_WAIT_SIM = 5;
  int mismatches = 0, total_checks = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  begs_block_erase_sequencer #(.ERASE_MIN(ERASE_MIN_SIM), .SIG_WAIT(SIG_WAIT_SIM)) dut (
    .clk(clk), .reset(reset),
    .start(start), .first_block_index(fi), .last_block_index(li), .erase_done(done),
    .sig_xfer_end(sx), .busy(busy), .erase_req(req), .erase_first_index(efi), .group_size(gs),
    .pass_count(pc), .status_valid(stv), .range_error(err), .sig_ready(rdy));
  begs_flash_model fm (.clk(clk), .erase_req(req), .dly(dly), .erase_done(done));
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task cmp(input string what, input logic [10:0] e, input logic [10:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %0d seen %0d", what, e, g);
    end
  endtask
  // which: 0 erase request, 1 status, 2 signature ready
  // sampled mid-cycle, well clear of the edge that launches the outputs
  task await(input int which, output int n);
    logic [2:0] v;
    n = 0;
    do begin
      @(negedge clk);
      v = {rdy, stv, req};
      n++;
    end while (v[which] !== 1'b1 && n < 500);
    // the bound stands in for the programmer's reply time-out
    if (v[which] !== 1'b1) begin
      mismatches++;
      summarize;
    end
  endtask
  task erase_range(input int f, l, m, d, p);
    int rem, at, g, n, t0, lim;
    @(posedge clk);
    {fi, li, dly, start} <= {f[9:0], l[9:0], d[7:0], 1'b1};
    @(posedge clk);
    start <= 1'b0;
    t0 = cyc;
    rem = l - f + 1;
    at = f;
    // scaled maximum wait: one cycle per 10 ms of reply budget
    lim = (11 + 2755 * m + 1379 * (rem > 0 ? rem : 0)) / 100;
    if (lim < ERASE_MIN_SIM + 4) lim = ERASE_MIN_SIM + 4;
    while (rem > 0) begin
      for (g = 128; g > rem || at % g != 0; g = g / 2);
      await(0, n);
      cmp("group_size", g[10:0], {3'h0, gs});
      cmp("first_index", at[10:0], {1'h0, efi});
      cmp("busy", 11'h001, {10'h000, busy});
      if (p != 0 && at == f) begin
        // a second start in mid-run must leave the sequence alone
        @(posedge clk);
        {fi, li, start} <= {10'h000, 10'h0FF, 1'b1};
        @(posedge clk);
        start <= 1'b0;
      end
      at += g;
      rem -= g;
    end
    await(1, n);
    cmp("pass_count", m[10:0], pc);
    cmp("range_error", {10'h000, l < f}, {10'h000, err});
    cmp("busy", 11'h000, {10'h000, busy});
    cmp("reply_min", 11'h001, {10'h000, cyc - t0 >= ERASE_MIN_SIM});
    cmp("reply_max", 11'h001, {10'h000, cyc - t0 <= lim});
    $display("range %0d to %0d done", f, l);
  endtask
  task sig_check;
    int n;
    // two transfers in a row, the second only once the device is ready
    repeat (2) begin
      @(posedge clk);
      sx <= 1'b1;
      @(posedge clk);
      sx <= 1'b0;
      @(negedge clk);
      cmp("sig_ready", 11'h000, {10'h000, rdy});
      await(2, n);
      cmp("sig_gap", 11'(SIG_WAIT_SIM), 11'(n));
    end
    $display("signature gap done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    erase_range(1, 127, 7, 0, 0);
    erase_range(5, 10, 4, 9, 1);
    erase_range(25, 73, 6, 3, 0);
    erase_range(0, 255, 2, 0, 0);
    erase_range(9, 3, 0, 1, 0);
    sig_check;
    summarize;
  end
endmodule // begs_block_erase_sequencer_bench
`default_nettype wire
